// file: pam_checker.sv
// Purpose: Concurrent checks on the pin mux ports.
// Assumes: pready is high, so every APB access phase commits.
// Notes: Input routes lag the pin by three edges.
`timescale 1ns/1ps
`default_nettype none
module pam_checker
   import pam_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic pready,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [7:0] p0_pin_in,
   input wire logic [7:0] p0_pin_out,
   input wire logic [7:0] p0_pin_oe,
   input wire logic [7:0] p3_pin_in,
   input wire logic [7:0] p3_pin_out,
   input wire logic [7:0] p3_pin_oe,
   input wire pam_periph_out_t periph_out,
   input wire pam_periph_in_t periph_in
);
   logic [7:0] a0, a3, s3; // Shadows of the enable and select bits.
   logic dbg; // Shadow of the debug mode bit.
   logic wr; // A write commits at this edge.
   logic t30; // Expected drive of port3_pin0.
   assign wr = psel & penable & pwrite & pready;
   assign t30 = s3[0] ? periph_out.timer_output_2 : periph_out.uart0_transmit;
   // The shadows copy writes at the same edge the block stores them.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         a0 <= 8'h00;
         a3 <= 8'h00;
         s3 <= 8'h00;
         dbg <= 1'h0;
      end else if (wr) begin
         a0 <= (paddr == PAM_OFS_P0_ALT_EN) ? pwdata[7:0] : a0;
         a3 <= (paddr == PAM_OFS_P3_ALT_EN) ? pwdata[7:0] : a3;
         s3 <= (paddr == PAM_OFS_P3_ALT_SEL) ? pwdata[7:0] : s3;
         dbg <= (paddr == PAM_OFS_DEBUG) ? pwdata[PAM_DEBUG_BIT] : dbg;
      end
   end
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   a_timer_a_pin: assert property (
      a0[0] |=> p0_pin_oe[0] && p0_pin_out[0] == $past(periph_out.timer8_output_a))
      else $error("Pin 0 misses timer A.");
   a_timer_b_pin: assert property (
      a0[1] |=> p0_pin_oe[1] && p0_pin_out[1] == $past(periph_out.timer8_output_b))
      else $error("Pin 1 misses timer B.");
   a_nmi_route: assert property (
      periph_in.nmi_in == ($past(a0[2]) & $past(p0_pin_in[2], 3)))
      else $error("Bad NMI level.");
   a_int0_route: assert property (
      periph_in.ext_interrupt_in_0 == ($past(a0[3]) & $past(p0_pin_in[3], 3)))
      else $error("Bad interrupt 0 level.");
   a_int2_gate: assert property (
      periph_in.ext_interrupt_in_2 == ($past(a0[5]) & !$past(dbg) & $past(p0_pin_in[5], 3)))
      else $error("Bad interrupt 2 level.");
   a_debug_reset: assert property (
      periph_in.debug_reset_input == ($past(dbg) & $past(p0_pin_in[5], 3)))
      else $error("Bad debug reset level.");
   a_p30_drive: assert property (
      a3[0] |=> p3_pin_oe[0] && p3_pin_out[0] == $past(t30))
      else $error("Bad port3 pin 0 drive.");
   a_rx_pair: assert property (
      $past(a3[1]) && !$past(s3[1]) |-> periph_in.uart0_receive == $past(p3_pin_in[1], 3)
      && periph_in.ext_interrupt_in_7 == periph_in.uart0_receive) else $error("Bad receive pair.");
   a_clk_pair: assert property (
      $past(a3[2]) && !$past(s3[2]) |-> periph_in.adc_trigger_in == $past(p3_pin_in[2], 3)
      && periph_in.uart0_ext_clock_in == periph_in.adc_trigger_in) else $error("Bad clock pair.");
endmodule
`default_nettype wire

// file: pam_mux.sv
// Purpose: APB-configured pin multiplexer for port 0, port 1 and port 3 pins 0 to 2.
// Assumes: pin_in arrives asynchronously; peripherals run on pclk.
// Notes: Pin outputs and enables are registered; peripheral inputs are synchronized.
// What this block does
// - Alt enable drives port0_pin0 from timer A.
// - Alt enable drives port0_pin1 from timer B.
// - Alt enable makes port0_pin2 the NMI input.
// - Pins 3,4,6 become external interrupts 0,1,3.
// - Pin 5 is interrupt 2 outside debug.
// - Debug mode makes pin 5 debug reset.
// - Port3 pin0 selects UART transmit or timer 2.
// - Port3 pin1 feeds UART receive and interrupt 7, or carries timer 3.
// - Port3 pin2 feeds UART clock and ADC trigger, or carries timer 1.
// - Alternate function fixes direction, ignores latch.
// - Enable 0 is GPIO (except pin 5 in debug mode), 1 is alternate.
`timescale 1ns/1ps
`default_nettype none
module pam_mux
   import pam_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic [7:0] p0_pin_in,
   output logic [7:0] p0_pin_out,
   output logic [7:0] p0_pin_oe,
   input wire logic [7:0] p1_pin_in,
   output logic [7:0] p1_pin_out,
   output logic [7:0] p1_pin_oe,
   input wire logic [7:0] p3_pin_in,
   output logic [7:0] p3_pin_out,
   output logic [7:0] p3_pin_oe,
   input wire pam_periph_out_t periph_out,
   output pam_periph_in_t periph_in
);

   // Register file contents.
   pam_cfg_t cfg;
   pam_cfg_t next_cfg;
   // Registered read data.
   logic [31:0] next_prdata;
   logic next_pslverr;
   // Synchronized pin levels.
   logic [23:0] pin_sync;
   logic [7:0] p0_sync;
   logic [7:0] p1_sync;
   logic [7:0] p3_sync;
   // Next pin drive values.
   logic [7:0] next_p0_out;
   logic [7:0] next_p0_oe;
   logic [7:0] next_p1_out;
   logic [7:0] next_p1_oe;
   logic [7:0] next_p3_out;
   logic [7:0] next_p3_oe;
   pam_periph_in_t next_periph_in;
   // Access strobes.
   // The write strobe marks the access phase; the read strobe marks the setup phase.
   logic wr_acc;
   logic rd_acc;

   // Used to raise the error flag; keeping the list apart from the read decode means
   // a new register must be added in both places.
   // Decodes whether an address is one of the mapped registers.
   function automatic logic addr_mapped(input logic [11:0] a);
      unique case (a)
         PAM_OFS_P0_LATCH, PAM_OFS_P0_DIR, PAM_OFS_P0_ALT_EN, PAM_OFS_P1_LATCH,
         PAM_OFS_P1_DIR, PAM_OFS_P3_LATCH, PAM_OFS_P3_DIR, PAM_OFS_P3_ALT_EN,
         PAM_OFS_P3_ALT_SEL, PAM_OFS_DEBUG, PAM_OFS_PIN_IN: addr_mapped = 1'b1;
         default: addr_mapped = 1'b0;
      endcase
   endfunction

   // General-purpose pin drive: direction bit 0 means output.
   // Returns the enable in the upper bit and the level in the lower bit.
   function automatic logic [1:0] gpio_drive(input logic latch, input logic dir);
      gpio_drive = {~dir, latch};
   endfunction

   // Every input pin passes two flops before any logic reads it.
   // The three ports share one bank; bits 7:0 are port 0, 15:8 port 1 and 23:16 port 3,
   // so one synchronizer serves them all and they all lag by the same two edges.
   pam_sync u_sync (
      .pclk(pclk),
      .presetn(presetn),
      .async_in({p3_pin_in, p1_pin_in, p0_pin_in}),
      .sync_out(pin_sync)
   );

   assign p0_sync = pin_sync[7:0];
   assign p1_sync = pin_sync[15:8];
   assign p3_sync = pin_sync[23:16];

   // The bus never stalls: every register is a plain flop, so there is nothing to wait for.
   // A master that allows for wait states still works, since it simply sees ready at once.
   // Slave answers with no wait states; errors only on unmapped addresses.
   assign pready = 1'b1;
   assign wr_acc = psel & penable & pwrite;
   assign rd_acc = psel & ~penable & ~pwrite;

   // Only the low byte of each write lands; the upper bits are dropped on purpose,
   // since every port is eight pins wide and nothing lives above them.
   // The pin-level register at the end of the map is read-only, so a write to it falls
   // into the default branch and leaves the configuration as it was.
   // Register writes take effect at the access-phase edge.
   always_comb begin
      next_cfg = cfg;
      if (wr_acc) begin
         unique case (paddr)
            PAM_OFS_P0_LATCH: next_cfg.p0_latch = pwdata[7:0];
            PAM_OFS_P0_DIR: next_cfg.p0_dir = pwdata[7:0];
            PAM_OFS_P0_ALT_EN: next_cfg.p0_alt = pwdata[7:0];
            PAM_OFS_P1_LATCH: next_cfg.p1_latch = pwdata[7:0];
            PAM_OFS_P1_DIR: next_cfg.p1_dir = pwdata[7:0];
            PAM_OFS_P3_LATCH: next_cfg.p3_latch = pwdata[7:0];
            PAM_OFS_P3_DIR: next_cfg.p3_dir = pwdata[7:0];
            PAM_OFS_P3_ALT_EN: next_cfg.p3_alt = pwdata[7:0];
            PAM_OFS_P3_ALT_SEL: next_cfg.p3_sel = pwdata[7:0];
            PAM_OFS_DEBUG: next_cfg.debug = pwdata[PAM_DEBUG_BIT];
            default: next_cfg = cfg;
         endcase
      end
   end

   // Loading the read word one cycle early keeps prdata a flop and still meets the
   // access phase, at the price of showing the configuration as it stood in setup.
   // A write and a read never overlap on one bus, so that snapshot is never stale.
   // Read data is captured in the setup cycle so it is a flop in the access phase.
   always_comb begin
      next_prdata = prdata;
      next_pslverr = 1'b0;
      if (rd_acc) begin
         unique case (paddr)
            PAM_OFS_P0_LATCH: next_prdata = {24'h000000, cfg.p0_latch};
            PAM_OFS_P0_DIR: next_prdata = {24'h000000, cfg.p0_dir};
            PAM_OFS_P0_ALT_EN: next_prdata = {24'h000000, cfg.p0_alt};
            PAM_OFS_P1_LATCH: next_prdata = {24'h000000, cfg.p1_latch};
            PAM_OFS_P1_DIR: next_prdata = {24'h000000, cfg.p1_dir};
            PAM_OFS_P3_LATCH: next_prdata = {24'h000000, cfg.p3_latch};
            PAM_OFS_P3_DIR: next_prdata = {24'h000000, cfg.p3_dir};
            PAM_OFS_P3_ALT_EN: next_prdata = {24'h000000, cfg.p3_alt};
            PAM_OFS_P3_ALT_SEL: next_prdata = {24'h000000, cfg.p3_sel};
            PAM_OFS_DEBUG: next_prdata = {31'h00000000, cfg.debug};
            PAM_OFS_PIN_IN: next_prdata = {8'h00, p3_sync, p1_sync, p0_sync};
            default: next_prdata = 32'h00000000;
         endcase
      end
      // Error flag is set in setup and held into the access phase.
      if (psel & ~penable) begin
         next_pslverr = ~addr_mapped(paddr);
      end else if (psel & penable) begin
         next_pslverr = pslverr;
      end
   end

   // Register file and bus answer flops.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cfg.p0_latch <= PAM_RST_LATCH;
         cfg.p0_dir <= PAM_RST_DIR;
         cfg.p0_alt <= PAM_RST_ALT;
         cfg.p1_latch <= PAM_RST_LATCH;
         cfg.p1_dir <= PAM_RST_DIR;
         cfg.p3_latch <= PAM_RST_LATCH;
         cfg.p3_dir <= PAM_RST_DIR;
         cfg.p3_alt <= PAM_RST_ALT;
         cfg.p3_sel <= PAM_RST_ALT;
         cfg.debug <= PAM_RST_DEBUG;
         prdata <= 32'h00000000;
         pslverr <= 1'b0;
      end else begin
         cfg <= next_cfg;
         prdata <= next_prdata;
         pslverr <= next_pslverr;
      end
   end

   // The drive logic starts from the general-purpose view and lets each enabled
   // alternate function overwrite its own pin, so a pin with its enable bit clear
   // is never touched by a peripheral, except pin 5, which debug mode takes over.
   // Output functions force the driver on and input functions force it off; the
   // latch and direction bits keep their values and return when the enable clears.
   // Pin drive and peripheral input selection.
   always_comb begin
      // Start with plain GPIO on every pin.
      for (int i = 0; i < 8; i++) begin
         {next_p0_oe[i], next_p0_out[i]} = gpio_drive(cfg.p0_latch[i], cfg.p0_dir[i]);
         {next_p1_oe[i], next_p1_out[i]} = gpio_drive(cfg.p1_latch[i], cfg.p1_dir[i]);
         {next_p3_oe[i], next_p3_out[i]} = gpio_drive(cfg.p3_latch[i], cfg.p3_dir[i]);
      end
      // Inputs rest low unless the pin is handed to that function.
      next_periph_in = '0;

      // Timer outputs override latch and direction.
      if (cfg.p0_alt[0]) begin
         next_p0_oe[0] = 1'b1;
         next_p0_out[0] = periph_out.timer8_output_a;
      end
      if (cfg.p0_alt[1]) begin
         next_p0_oe[1] = 1'b1;
         next_p0_out[1] = periph_out.timer8_output_b;
      end
      // Input functions release the driver whatever the direction bit says.
      if (cfg.p0_alt[2]) begin
         next_p0_oe[2] = 1'b0;
         next_periph_in.nmi_in = p0_sync[2];
      end
      // External interrupts 0, 1 and 3.
      if (cfg.p0_alt[3]) begin
         next_p0_oe[3] = 1'b0;
         next_periph_in.ext_interrupt_in_0 = p0_sync[3];
      end
      if (cfg.p0_alt[4]) begin
         next_p0_oe[4] = 1'b0;
         next_periph_in.ext_interrupt_in_1 = p0_sync[4];
      end
      if (cfg.p0_alt[6]) begin
         next_p0_oe[6] = 1'b0;
         next_periph_in.ext_interrupt_in_3 = p0_sync[6];
      end
      // The debug reset must reach the debugger even if software has handed the pin
      // to something else, so it is tested first and overrides the enable bit.
      // Debug mode wins over the enable bit on pin 5.
      if (cfg.debug) begin
         next_p0_oe[5] = 1'b0;
         next_periph_in.debug_reset_input = p0_sync[5];
      end else if (cfg.p0_alt[5]) begin
         next_p0_oe[5] = 1'b0;
         next_periph_in.ext_interrupt_in_2 = p0_sync[5];
      end

      // Port 1 has no enable bits of its own; its pins stay general-purpose and the
      // analog block only learns whether software has made every pin an input.
      // Analog outputs are reported usable only with all-ones direction.
      next_periph_in.analog_out_enable = (cfg.p1_dir == PAM_P1_ANALOG_DIR);

      // Port 3 pin 0: UART transmit or timer 2.
      if (cfg.p3_alt[0]) begin
         next_p3_oe[0] = 1'b1;
         next_p3_out[0] = cfg.p3_sel[0] ? periph_out.timer_output_2
                                         : periph_out.uart0_transmit;
      end
      // Both shared inputs see the same level; software must keep the unused one
      // quiet, since the mux cannot tell which peripheral the pin is meant for.
      // Port 3 pin 1: shared input or timer 3; one level reaches both.
      if (cfg.p3_alt[1]) begin
         if (cfg.p3_sel[1]) begin
            next_p3_oe[1] = 1'b1;
            next_p3_out[1] = periph_out.timer_output_3;
         end else begin
            next_p3_oe[1] = 1'b0;
            next_periph_in.uart0_receive = p3_sync[1];
            next_periph_in.ext_interrupt_in_7 = p3_sync[1];
         end
      end
      // Port 3 pin 2: shared input or timer 1.
      if (cfg.p3_alt[2]) begin
         if (cfg.p3_sel[2]) begin
            next_p3_oe[2] = 1'b1;
            next_p3_out[2] = periph_out.timer_output_1;
         end else begin
            next_p3_oe[2] = 1'b0;
            next_periph_in.uart0_ext_clock_in = p3_sync[2];
            next_periph_in.adc_trigger_in = p3_sync[2];
         end
      end
   end

   // Registering the pin drive costs one cycle from a peripheral to its pin, but
   // keeps every output free of glitches from the decode above.
   // The peripheral inputs are registered in the same process so that a level shared
   // by two inputs reaches both on one edge and never through two different paths.
   // Pin and peripheral-input flops; a shared level lands in both fields on one edge.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         p0_pin_out <= 8'h00;
         p0_pin_oe <= 8'h00;
         p1_pin_out <= 8'h00;
         p1_pin_oe <= 8'h00;
         p3_pin_out <= 8'h00;
         p3_pin_oe <= 8'h00;
         periph_in <= '0;
      end else begin
         p0_pin_out <= next_p0_out;
         p0_pin_oe <= next_p0_oe;
         p1_pin_out <= next_p1_out;
         p1_pin_oe <= next_p1_oe;
         p3_pin_out <= next_p3_out;
         p3_pin_oe <= next_p3_oe;
         periph_in <= next_periph_in;
      end
   end

endmodule
`default_nettype wire

// file: pam_mux_tb.sv
// Purpose: Self-checking bench for the pin mux.
// Assumes: Pins are judged at the falling edge after they settle.
// Notes: Inputs need three edges to reach the peripherals.
`timescale 1ns/1ps
`default_nettype none
`define PAM_CHK(nm, exp, got) begin \
   tests_run++; \
   if ((got) !== (exp)) begin \
      bad_count++; \
      $display("unexpected %s exp %0h got %0h", nm, exp, got); \
   end \
end
module pam_mux_tb
   import pam_pkg::*;
   ;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [7:0] p0_pin_in, p0_pin_out, p0_pin_oe, p1_pin_in, p1_pin_out, p1_pin_oe;
   logic [7:0] p3_pin_in, p3_pin_out, p3_pin_oe;
   pam_periph_out_t periph_out, po;
   pam_periph_in_t periph_in;
   int bad_count = 0;
   int tests_run = 0;
   pam_mux i_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
      .pslverr, .p0_pin_in, .p0_pin_out, .p0_pin_oe, .p1_pin_in, .p1_pin_out, .p1_pin_oe,
      .p3_pin_in, .p3_pin_out, .p3_pin_oe, .periph_out, .periph_in);
   pam_periph_model i_per (.pclk, .presetn, .periph_out);
   // Clock at 20 MHz.
   initial begin
      pclk = 1'b0;
      forever #25 pclk = ~pclk;
   end
   // One APB transfer; the request stands until pready is seen high.
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   // Let n edges pass, keep the peripheral levels of the last one.
   task automatic settle(input int n);
      repeat (n) @(posedge pclk);
      po = periph_out;
      @(negedge pclk);
   endtask
   task automatic t_reset();
      `PAM_CHK("oe", 8'h00, p0_pin_oe)
      apb(1'b0, PAM_OFS_P0_DIR, 32'h0);
      `PAM_CHK("dir", {24'h0, PAM_RST_DIR}, rd)
      $display("reset test done");
   endtask
   // Alternate outputs override latch and direction.
   task automatic t_gpio();
      apb(1'b1, PAM_OFS_P0_LATCH, 32'hA5);
      apb(1'b1, PAM_OFS_P0_DIR, 32'h0F);
      settle(1);
      `PAM_CHK("gpio oe", 8'hF0, p0_pin_oe)
      `PAM_CHK("gpio out", 4'hA, p0_pin_out[7:4])
      apb(1'b1, PAM_OFS_P0_ALT_EN, 32'h03);
      settle(1);
      `PAM_CHK("tmr a", po.timer8_output_a, p0_pin_out[0])
      `PAM_CHK("tmr b", po.timer8_output_b, p0_pin_out[1])
      `PAM_CHK("alt oe", 2'h3, p0_pin_oe[1:0])
      $display("gpio test done");
   endtask
   task automatic t_inputs();
      logic [7:0] v;
      apb(1'b1, PAM_OFS_P0_ALT_EN, 32'h7C);
      for (int i = 0; i < 2; i++) begin
         v = i ? 8'h28 : 8'h54;
         @(posedge pclk);
         p0_pin_in <= v;
         settle(4);
         `PAM_CHK("nmi", v[2], periph_in.nmi_in)
         `PAM_CHK("int0", v[3], periph_in.ext_interrupt_in_0)
         `PAM_CHK("int1", v[4], periph_in.ext_interrupt_in_1)
         `PAM_CHK("int3", v[6], periph_in.ext_interrupt_in_3)
         `PAM_CHK("int2", v[5], periph_in.ext_interrupt_in_2)
         `PAM_CHK("in oe", 5'h00, p0_pin_oe[6:2])
      end
      apb(1'b1, PAM_OFS_DEBUG, 32'h1);
      settle(4);
      `PAM_CHK("debug_reset_input", 1'b1, periph_in.debug_reset_input)
      `PAM_CHK("int2 off", 1'b0, periph_in.ext_interrupt_in_2)
      apb(1'b1, PAM_OFS_P0_ALT_EN, 32'h5C);
      settle(1);
      `PAM_CHK("debug_reset_input no alt", 1'b1, periph_in.debug_reset_input)
      apb(1'b1, PAM_OFS_DEBUG, 32'h0);
      $display("input test done");
   endtask
   // No receiver or trigger unit runs, so the shared pins never clash.
   task automatic t_port3();
      apb(1'b1, PAM_OFS_P3_ALT_EN, 32'h07);
      for (int s = 0; s < 2; s++) begin
         apb(1'b1, PAM_OFS_P3_ALT_SEL, s ? 32'h07 : 32'h00);
         p3_pin_in <= 8'h06;
         settle(4);
         `PAM_CHK("p30", s ? po.timer_output_2 : po.uart0_transmit, p3_pin_out[0])
         `PAM_CHK("rxd", (s == 0), periph_in.uart0_receive)
         `PAM_CHK("int7", (s == 0), periph_in.ext_interrupt_in_7)
         `PAM_CHK("trig", (s == 0), periph_in.adc_trigger_in)
         `PAM_CHK("uclk", (s == 0), periph_in.uart0_ext_clock_in)
         `PAM_CHK("p3 oe", s ? 3'h7 : 3'h1, p3_pin_oe[2:0])
      end
      `PAM_CHK("p31", po.timer_output_3, p3_pin_out[1])
      `PAM_CHK("p32", po.timer_output_1, p3_pin_out[2])
      $display("port3 test done");
   endtask
   task automatic t_misc();
      apb(1'b1, PAM_OFS_P1_LATCH, 32'hC3);
      apb(1'b1, PAM_OFS_P1_DIR, 32'h7F);
      settle(1);
      `PAM_CHK("ana off", 1'b0, periph_in.analog_out_enable)
      `PAM_CHK("p1 out", 8'hC3, p1_pin_out)
      `PAM_CHK("p1 oe", 8'h80, p1_pin_oe)
      apb(1'b1, PAM_OFS_P1_DIR, 32'hFF);
      settle(1);
      `PAM_CHK("ana on", 1'b1, periph_in.analog_out_enable)
      apb(1'b0, 12'hFFC, 32'h0);
      `PAM_CHK("unmapped", 33'h100000000, {err, rd})
      `PAM_CHK("ready", 1'b1, pready)
      apb(1'b0, PAM_OFS_PIN_IN, 32'h0);
      `PAM_CHK("pins", {8'h00, p3_pin_in, p1_pin_in, p0_pin_in}, rd)
      $display("misc test done");
   endtask
   task automatic end_of_test();
      $display("checks %0d mismatches %0d", tests_run, bad_count);
      if (bad_count == 0 && tests_run > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask
   // A hang counts as a mismatch.
   initial begin
      repeat (3000) @(posedge pclk);
      bad_count++;
      end_of_test();
   end
   initial begin
      {psel, penable, pwrite, presetn} = 4'h0;
      paddr = 12'h000;
      pwdata = 32'h0;
      p0_pin_in = 8'h00;
      p1_pin_in = 8'h3C;
      p3_pin_in = 8'h00;
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      t_reset();
      t_gpio();
      t_inputs();
      t_port3();
      t_misc();
      end_of_test();
   end
endmodule
bind pam_mux pam_checker i_chk (.pclk, .presetn, .psel, .penable, .pwrite, .pready, .paddr,
   .pwdata, .p0_pin_in, .p0_pin_out, .p0_pin_oe, .p3_pin_in, .p3_pin_out, .p3_pin_oe,
   .periph_out, .periph_in);
`default_nettype wire

// file: pam_periph_model.sv
// Purpose: Behavioural timers and UART transmitter facing the mux.
// Assumes: Peripheral outputs change just after pclk edges.
// Notes: Outputs differ in rate or polarity, so a crossed route shows.
`timescale 1ns/1ps
`default_nettype none
module pam_periph_model
   import pam_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   output pam_periph_out_t periph_out
);
   logic [7:0] cnt; // Free-running phase counter.
   logic [7:0] next_cnt; // Next counter value.
   // Count every cycle; the outputs are counter bits 0 to 3, two of them also inverted.
   always_comb begin
      next_cnt = cnt + 8'h01;
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt <= 8'h00;
      end else begin
         cnt <= next_cnt;
      end
   end
   assign periph_out = {cnt[0], cnt[1], ~cnt[0], cnt[2], cnt[3], ~cnt[1]};
endmodule
`default_nettype wire

// file: pam_pkg.sv
// Purpose: Shared constants and carrier types for the port alternate-function mux.
// Assumes: One APB clock domain; 32-bit APB data, one aligned word per register.
// Notes: Register offsets are byte addresses.
package pam_pkg;

   // Register byte offsets.
   localparam logic [11:0] PAM_OFS_P0_LATCH = 12'h000;
   localparam logic [11:0] PAM_OFS_P0_DIR = 12'h004;
   localparam logic [11:0] PAM_OFS_P0_ALT_EN = 12'h008;
   localparam logic [11:0] PAM_OFS_P1_LATCH = 12'h010;
   localparam logic [11:0] PAM_OFS_P1_DIR = 12'h014;
   localparam logic [11:0] PAM_OFS_P3_LATCH = 12'h020;
   localparam logic [11:0] PAM_OFS_P3_DIR = 12'h024;
   localparam logic [11:0] PAM_OFS_P3_ALT_EN = 12'h028;
   localparam logic [11:0] PAM_OFS_P3_ALT_SEL = 12'h02C;
   localparam logic [11:0] PAM_OFS_DEBUG = 12'h030;
   localparam logic [11:0] PAM_OFS_PIN_IN = 12'h034;

   // Reset values: latches clear, directions input (1), alternate functions off.
   localparam logic [7:0] PAM_RST_LATCH = 8'h00;
   localparam logic [7:0] PAM_RST_DIR = 8'hFF;
   localparam logic [7:0] PAM_RST_ALT = 8'h00;
   localparam logic PAM_RST_DEBUG = 1'h0;

   // Field positions and the direction value that makes analog outputs legal.
   localparam int PAM_DEBUG_BIT = 0;
   localparam logic [7:0] PAM_P1_ANALOG_DIR = 8'hFF;

   // Port configuration seen by the mux.
   typedef struct packed {
      logic [7:0] p0_latch;
      logic [7:0] p0_dir;
      logic [7:0] p0_alt;
      logic [7:0] p1_latch;
      logic [7:0] p1_dir;
      logic [7:0] p3_latch;
      logic [7:0] p3_dir;
      logic [7:0] p3_alt;
      logic [7:0] p3_sel;
      logic debug;
   } pam_cfg_t;

   // Peripheral outputs that may drive pins.
   typedef struct packed {
      logic timer8_output_a;
      logic timer8_output_b;
      logic uart0_transmit;
      logic timer_output_1;
      logic timer_output_2;
      logic timer_output_3;
   } pam_periph_out_t;

   // Synchronized pin levels handed to peripheral inputs.
   typedef struct packed {
      logic nmi_in;
      logic ext_interrupt_in_0;
      logic ext_interrupt_in_1;
      logic ext_interrupt_in_2;
      logic ext_interrupt_in_3;
      logic ext_interrupt_in_7;
      logic debug_reset_input;
      logic uart0_receive;
      logic uart0_ext_clock_in;
      logic adc_trigger_in;
      logic analog_out_enable;
   } pam_periph_in_t;

endpackage

// file: pam_sync.sv
// Purpose: Two-flop synchronizer bank for pin input levels.
// Assumes: Pins are asynchronous to pclk.
// Notes: The first stage feeds only the second stage.
`timescale 1ns/1ps
`default_nettype none
module pam_sync (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic [23:0] async_in,
   output logic [23:0] sync_out
);

   // First stage, read only by the second stage.
   logic [23:0] stage1;
   logic [23:0] next_stage1;
   logic [23:0] next_sync_out;

   // Next values are the plain shift of the chain.
   always_comb begin
      next_stage1 = async_in;
      next_sync_out = stage1;
   end

   // Both stages clear on reset so that peripherals see a quiet level.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         stage1 <= 24'h000000;
         sync_out <= 24'h000000;
      end else begin
         stage1 <= next_stage1;
         sync_out <= next_sync_out;
      end
   end

endmodule
`default_nettype wire
